// ==== lee_consts.vh ====
`ifndef LEE_CONSTS_VH
`define LEE_CONSTS_VH
// register byte offsets
`define LEE_OFS_ERR_CTRL 8'h68
`define LEE_OFS_LINK_CTRL 8'h70
`define LEE_OFS_IRQ_STS 8'h74
`define LEE_OFS_IRQ_MASK 8'h78
// error control fields, word at 0x68
`define LEE_CTRL_W 24
`define LEE_CTRL_RST 24'h00_0000
`define LEE_CTRL_WMASK 24'h03_ffff
`define LEE_B_PROTO 0
`define LEE_B_OVF 3
`define LEE_B_CHAIN 6
`define LEE_B_CRC 9
`define LEE_B_SERR_FATAL 11
`define LEE_B_TAG 12
`define LEE_B_MAP 15
// error status flags, bits 28:24 of word 0x68
`define LEE_STS_LSB 24
`define LEE_F_PROTO 0
`define LEE_F_OVF 1
`define LEE_F_CHAIN 2
`define LEE_F_TAG 3
`define LEE_F_MAP 4
// link control word fields
`define LEE_L_SERR_ALLOW 0
`define LEE_L_CRC_FLAG 1
`define LEE_L_SERR_FLAG 2
`define LEE_L_LINK_FAIL 8
`define LEE_L_INIT_DONE 9
// interrupt status and mask fields
`define LEE_I_FATAL 0
`define LEE_I_NONFATAL 1
`define LEE_I_FLOOD 2
`define LEE_IRQ_W 3
`define LEE_SRCID_W 5
`endif

// ==== lee_sync.v ====
`timescale 1ns/100ps
// three-stage synchroniser; output follows once stages two and three agree
module lee_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_level
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] level_q;
  integer k;

  // stage one is read only by stage two
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end
    else
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (k = 0; k < WIDTH; k = k + 1)
        if (s2_q[k] == s3_q[k])
          level_q[k] <= s3_q[k];
    end
  end

  assign o_level = level_q;
endmodule // lee_sync

// ==== lee_class.v ====
`timescale 1ns/100ps
// one error class: sticky flag plus fatal, nonfatal and flood decisions
module lee_class (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_event,
  input wire i_clear,
  input wire i_fatal_en,
  input wire i_nonfatal_en,
  input wire i_flood_en,
  output wire o_flag,
  output wire o_fatal,
  output wire o_nonfatal,
  output wire o_flood
);
  reg flag_q;

  // set wins over a clear in the same cycle
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      flag_q <= 1'b0;
    else if (i_event)
      flag_q <= 1'b1;
    else if (i_clear)
      flag_q <= 1'b0;
  end

  // levels held while the flag stands, flood fires on the event itself
  assign o_flag = flag_q;
  assign o_fatal = flag_q & i_fatal_en;
  assign o_nonfatal = flag_q & i_nonfatal_en;
  assign o_flood = i_event & i_flood_en;
endmodule // lee_class

// ==== lee_link_err.v ====
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`include "lee_consts.vh"
module lee_link_err (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_link_clk,
  input wire i_link_proto_err,
  input wire i_link_ovf_err,
  input wire i_link_crc_err,
  input wire i_link_tag_err,
  input wire i_link_init_complete,
  input wire i_system_err,
  input wire i_req_valid,
  input wire i_req_posted,
  input wire i_req_nxa,
  input wire [`LEE_SRCID_W-1:0] i_req_srcid,
  output reg o_nxa_resp_valid,
  output reg [`LEE_SRCID_W-1:0] o_nxa_resp_srcid,
  output reg o_fatal_int,
  output reg o_nonfatal_int,
  output wire o_sync_flood,
  output wire o_link_failure,
  output wire o_irq
);
  // byte-lane merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] upd;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          merge[b*8 +: 8] = upd[b*8 +: 8];
    end
  endfunction

  reg [`LEE_CTRL_W-1:0] ctrl_q;
  reg serr_allow_q;
  reg crc_flag_q;
  reg serr_flag_q;
  reg link_fail_q;
  reg [`LEE_IRQ_W-1:0] irq_sts_q;
  reg [`LEE_IRQ_W-1:0] irq_mask_q;
  reg link_clk_d1_q;
  reg [31:0] rd_d;
  wire [3:0] lk_err;
  wire link_clk_lvl;
  wire lk_edge;
  wire [4:0] sync_in;
  wire [4:0] sync_out;
  wire wb_req;
  wire wr;
  wire [31:0] wr_one;
  wire [31:0] new_ctrl;
  wire [31:0] new_mask;
  wire [4:0] flag_clr;
  wire chain_evt;
  wire map_evt;
  wire send_nxa;
  wire crc_evt;
  wire [4:0] flag;
  wire [4:0] fat;
  wire [4:0] nfat;
  wire [4:0] fld;
  wire crc_fatal;
  wire crc_nonfatal;
  wire serr_on;
  wire fatal_d;
  wire nonfatal_d;
  wire flood_evt;
  wire [`LEE_IRQ_W-1:0] irq_evt;

  // link clock and link error lines share one synchroniser
  assign sync_in = {i_link_tag_err, i_link_crc_err, i_link_ovf_err, i_link_proto_err,
                    i_link_clk};
  lee_sync #(
    .WIDTH(5)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(sync_in),
    .o_level(sync_out)
  );
  assign link_clk_lvl = sync_out[0];
  assign lk_err = sync_out[4:1];

  // rising edge of the filtered link clock samples the error lines
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      link_clk_d1_q <= 1'b0;
    else
      link_clk_d1_q <= link_clk_lvl;
  end
  assign lk_edge = link_clk_lvl & ~link_clk_d1_q;

  // wishbone: ack one cycle after the request; a write lands on the edge that sees ack
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
  assign wr_one = merge(32'h0000_0000, i_wb_dat, i_wb_sel);
  assign new_ctrl = merge({8'h00, ctrl_q}, i_wb_dat, i_wb_sel);
  assign new_mask = merge({29'h0000_0000, irq_mask_q}, i_wb_dat, i_wb_sel);
  assign flag_clr = (wr && i_wb_adr == `LEE_OFS_ERR_CTRL) ?
                    wr_one[`LEE_STS_LSB +: 5] : 5'h00;

  // request screening against init state and address decode
  assign chain_evt = i_req_valid &
                     (~i_link_init_complete | (i_req_nxa & i_req_posted));
  assign send_nxa = i_req_valid & ~i_req_posted & (~i_link_init_complete | i_req_nxa);
  assign map_evt = send_nxa & (i_req_srcid == {`LEE_SRCID_W{1'b0}});
  assign crc_evt = lk_edge & lk_err[2];

  // error response back to the requester
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_nxa_resp_valid <= 1'b0;
      o_nxa_resp_srcid <= {`LEE_SRCID_W{1'b0}};
    end
    else
    begin
      o_nxa_resp_valid <= send_nxa;
      if (send_nxa)
        o_nxa_resp_srcid <= i_req_srcid;
    end
  end

  // protocol class
  lee_class u_proto (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_event(lk_edge & lk_err[0]),
    .i_clear(flag_clr[`LEE_F_PROTO]),
    .i_fatal_en(ctrl_q[`LEE_B_PROTO]),
    .i_nonfatal_en(ctrl_q[`LEE_B_PROTO+1]),
    .i_flood_en(ctrl_q[`LEE_B_PROTO+2]),
    .o_flag(flag[`LEE_F_PROTO]),
    .o_fatal(fat[0]),
    .o_nonfatal(nfat[0]),
    .o_flood(fld[0])
  );

  // receive overflow class
  lee_class u_ovf (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_event(lk_edge & lk_err[1]),
    .i_clear(flag_clr[`LEE_F_OVF]),
    .i_fatal_en(ctrl_q[`LEE_B_OVF]),
    .i_nonfatal_en(ctrl_q[`LEE_B_OVF+1]),
    .i_flood_en(ctrl_q[`LEE_B_OVF+2]),
    .o_flag(flag[`LEE_F_OVF]),
    .o_fatal(fat[1]),
    .o_nonfatal(nfat[1]),
    .o_flood(fld[1])
  );

  // end of chain class; unmatched responses join it through the synchronised tag error line
  lee_class u_chain (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_event(chain_evt | (lk_edge & lk_err[3])),
    .i_clear(flag_clr[`LEE_F_CHAIN]),
    .i_fatal_en(ctrl_q[`LEE_B_CHAIN]),
    .i_nonfatal_en(ctrl_q[`LEE_B_CHAIN+1]),
    .i_flood_en(ctrl_q[`LEE_B_CHAIN+2]),
    .o_flag(flag[`LEE_F_CHAIN]),
    .o_fatal(fat[2]),
    .o_nonfatal(nfat[2]),
    .o_flood(fld[2])
  );

  // source tag class
  lee_class u_tag (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_event(lk_edge & lk_err[3]),
    .i_clear(flag_clr[`LEE_F_TAG]),
    .i_fatal_en(ctrl_q[`LEE_B_TAG]),
    .i_nonfatal_en(ctrl_q[`LEE_B_TAG+1]),
    .i_flood_en(ctrl_q[`LEE_B_TAG+2]),
    .o_flag(flag[`LEE_F_TAG]),
    .o_fatal(fat[3]),
    .o_nonfatal(nfat[3]),
    .o_flood(fld[3])
  );

  // mapping class for zero source id error responses
  lee_class u_map (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_event(map_evt),
    .i_clear(flag_clr[`LEE_F_MAP]),
    .i_fatal_en(ctrl_q[`LEE_B_MAP]),
    .i_nonfatal_en(ctrl_q[`LEE_B_MAP+1]),
    .i_flood_en(ctrl_q[`LEE_B_MAP+2]),
    .o_flag(flag[`LEE_F_MAP]),
    .o_fatal(fat[4]),
    .o_nonfatal(nfat[4]),
    .o_flood(fld[4])
  );

  // checksum and system error conditions, no flood path for either
  assign crc_fatal = crc_flag_q & ctrl_q[`LEE_B_CRC];
  assign crc_nonfatal = crc_flag_q & ctrl_q[`LEE_B_CRC+1];
  assign serr_on = serr_flag_q & serr_allow_q;
  assign fatal_d = (|fat) | crc_fatal | (serr_on & ctrl_q[`LEE_B_SERR_FATAL]);
  assign nonfatal_d = (|nfat) | crc_nonfatal | (serr_on & ~ctrl_q[`LEE_B_SERR_FATAL]);
  assign flood_evt = |fld;
  assign irq_evt = {flood_evt, nonfatal_d & ~o_nonfatal_int, fatal_d & ~o_fatal_int};

  // registered interrupt levels
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_fatal_int <= 1'b0;
      o_nonfatal_int <= 1'b0;
    end
    else
    begin
      o_fatal_int <= fatal_d;
      o_nonfatal_int <= nonfatal_d;
    end
  end

  // software state and sticky bits; every set wins over its clear
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_q <= `LEE_CTRL_RST;
      serr_allow_q <= 1'b0;
      crc_flag_q <= 1'b0;
      serr_flag_q <= 1'b0;
      link_fail_q <= 1'b0;
      irq_sts_q <= {`LEE_IRQ_W{1'b0}};
      irq_mask_q <= {`LEE_IRQ_W{1'b0}};
    end
    else
    begin
      if (wr && i_wb_adr == `LEE_OFS_ERR_CTRL)
        ctrl_q <= new_ctrl[`LEE_CTRL_W-1:0] & `LEE_CTRL_WMASK; // reserved bits stay zero
      if (wr && i_wb_adr == `LEE_OFS_LINK_CTRL && i_wb_sel[0])
        serr_allow_q <= i_wb_dat[`LEE_L_SERR_ALLOW];
      if (wr && i_wb_adr == `LEE_OFS_IRQ_MASK)
        irq_mask_q <= new_mask[`LEE_IRQ_W-1:0];
      if (crc_evt)
        crc_flag_q <= 1'b1;
      else if (wr && i_wb_adr == `LEE_OFS_LINK_CTRL && wr_one[`LEE_L_CRC_FLAG])
        crc_flag_q <= 1'b0;
      if (i_system_err)
        serr_flag_q <= 1'b1;
      else if (wr && i_wb_adr == `LEE_OFS_LINK_CTRL && wr_one[`LEE_L_SERR_FLAG])
        serr_flag_q <= 1'b0;
      if (flood_evt)
        link_fail_q <= 1'b1;
      else if (wr && i_wb_adr == `LEE_OFS_LINK_CTRL && wr_one[`LEE_L_LINK_FAIL])
        link_fail_q <= 1'b0;
      if (wr && i_wb_adr == `LEE_OFS_IRQ_STS)
        irq_sts_q <= (irq_sts_q & ~wr_one[`LEE_IRQ_W-1:0]) | irq_evt;
      else
        irq_sts_q <= irq_sts_q | irq_evt;
    end
  end

  // flooding lasts as long as the link failure flag
  assign o_sync_flood = link_fail_q;
  assign o_link_failure = link_fail_q;
  assign o_irq = |(irq_sts_q & irq_mask_q);

  // read mux; unmapped offsets read zero
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (i_wb_adr)
      `LEE_OFS_ERR_CTRL:
        rd_d = {3'b000, flag, ctrl_q};
      `LEE_OFS_LINK_CTRL:
      begin
        rd_d[`LEE_L_SERR_ALLOW] = serr_allow_q;
        rd_d[`LEE_L_CRC_FLAG] = crc_flag_q;
        rd_d[`LEE_L_SERR_FLAG] = serr_flag_q;
        rd_d[`LEE_L_LINK_FAIL] = link_fail_q;
        rd_d[`LEE_L_INIT_DONE] = i_link_init_complete;
      end
      `LEE_OFS_IRQ_STS:
        rd_d[`LEE_IRQ_W-1:0] = irq_sts_q;
      `LEE_OFS_IRQ_MASK:
        rd_d[`LEE_IRQ_W-1:0] = irq_mask_q;
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  // ack and read data
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
        o_wb_dat <= rd_d;
    end
  end
endmodule // lee_link_err

// ==== lee_link_err_properties.sv ====
`timescale 1ns/100ps
// port-level checks of the error escalation block
module lee_link_err_properties (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire o_wb_ack,
  input wire i_req_valid,
  input wire i_req_posted,
  input wire i_req_nxa,
  input wire [4:0] i_req_srcid,
  input wire i_link_init_complete,
  input wire o_nxa_resp_valid,
  input wire [4:0] o_nxa_resp_srcid,
  input wire o_fatal_int,
  input wire o_link_failure,
  input wire o_irq
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  // error responses follow their request by one cycle
  AST_NXA_RESP: assert property (
    i_req_valid && !i_req_posted && i_req_nxa |=> o_nxa_resp_valid)
    else $error("error response missing");
  AST_POSTED: assert property (
    i_req_valid && i_req_posted |=> !o_nxa_resp_valid)
    else $error("posted request answered");
  AST_INIT: assert property (
    i_req_valid && !i_req_posted && !i_link_init_complete |=> o_nxa_resp_valid)
    else $error("early request not rejected");
  AST_SRCID: assert property (
    o_nxa_resp_valid |-> o_nxa_resp_srcid == $past(i_req_srcid))
    else $error("response source id wrong");
  AST_ACK: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus answer not one pulse");
  // sticky outputs only drop after a software write
  AST_FAIL_HOLD: assert property (
    $fell(o_link_failure) |-> $past(i_wb_cyc && i_wb_we))
    else $error("link failure dropped alone");
  AST_FATAL_HOLD: assert property (
    $fell(o_fatal_int) |-> $past(i_wb_cyc && i_wb_we, 2))
    else $error("fatal dropped alone");
  AST_IRQ_HOLD: assert property (
    $fell(o_irq) |-> $past(i_wb_cyc && i_wb_we))
    else $error("irq dropped alone");
  // main scenarios reached
  cover property (o_nxa_resp_valid);
  cover property ($rose(o_link_failure));
  cover property ($fell(o_irq));
endmodule // lee_link_err_properties

// ==== lee_peer.sv ====
`timescale 1ns/100ps
// peer link device; its clock only runs within an error frame
module lee_peer (
  output reg o_link_clk,
  output reg [3:0] o_err
);
  initial
  begin
    o_link_clk = 1'h0;
    o_err = 4'h0;
  end
  // hold error levels over two link clock rises, then idle
  task frame(input [3:0] m);
    integer i;
    begin
      #3 o_err = m; // keep the link off the system clock edges
      for (i = 0; i < 4; i = i + 1)
      begin
        #80 o_link_clk = ~o_link_clk;
      end
      #40 o_err = 4'h0;
    end
  endtask
endmodule // lee_peer

// ==== link_error_escalation_test.sv ====
`timescale 1ns/100ps
module link_error_escalation_test;
  reg clk = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  reg req = 1'h0, pst = 1'h0, nxa = 1'h0, init = 1'h1, serr = 1'h0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat = 32'h0000_0000;
  reg [31:0] rd;
  reg [4:0] sid = 5'h00;
  reg [51:0] t [0:12];
  wire [31:0] q;
  wire [4:0] rs;
  wire [3:0] le;
  wire ack, rv, fat, nf, fl, lf, irq, lclk;
  integer n_errors = 0;
  integer num_checks = 0;
  integer k;
  lee_link_err u_dut (
    .i_clk_sys(clk),
    .i_resetn(rstn),
    .i_wb_cyc(cyc),
    .i_wb_stb(stb),
    .i_wb_we(we),
    .i_wb_adr(adr),
    .i_wb_sel(sel),
    .i_wb_dat(dat),
    .o_wb_dat(q),
    .o_wb_ack(ack),
    .i_link_clk(lclk),
    .i_link_proto_err(le[0]),
    .i_link_ovf_err(le[1]),
    .i_link_crc_err(le[2]),
    .i_link_tag_err(le[3]),
    .i_link_init_complete(init),
    .i_system_err(serr),
    .i_req_valid(req),
    .i_req_posted(pst),
    .i_req_nxa(nxa),
    .i_req_srcid(sid),
    .o_nxa_resp_valid(rv),
    .o_nxa_resp_srcid(rs),
    .o_fatal_int(fat),
    .o_nonfatal_int(nf),
    .o_sync_flood(fl),
    .o_link_failure(lf),
    .o_irq(irq)
  );
  lee_peer u_peer (
    .o_link_clk(lclk),
    .o_err(le)
  );
  // 100 MHz clock and two-cycle reset
  always #5 clk = ~clk;
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task bus(input [7:0] a, input [31:0] d, input [3:0] s, input w);
    begin
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      adr <= a;
      dat <= d;
      sel <= s;
      we <= w;
      @(posedge clk);
      while (ack !== 1'h1) @(posedge clk);
      rd = q;
      cyc <= 1'h0;
      stb <= 1'h0;
    end
  endtask
  // raise one error event: link line, system error or request
  task fire(input [3:0] c);
    begin
      if (c < 4'h4)
        u_peer.frame(4'h1 << c);
      else
      begin
        @(posedge clk);
        serr <= (c == 4'h4);
        req <= (c > 4'h4);
        pst <= (c == 4'h5);
        nxa <= (c != 4'h7);
        init <= (c != 4'h7);
        sid <= (c == 4'h6) ? 5'h00 : 5'h05;
        @(posedge clk);
        serr <= 1'h0;
        req <= 1'h0;
        @(posedge clk);
        init <= 1'h1;
        if (c > 4'h4)
          chk({31'h0, rv}, {31'h0, c != 4'h5});
        if (c > 4'h5)
          chk({27'h0, rs}, {27'h0, sid});
      end
    end
  endtask
  // watchdog
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  // table: kind, link ctrl, fatal/nonfatal/flood, flag bits, enables
  initial
  begin
    t[0] = {4'h0, 4'h0, 4'h2, 8'h01, 32'h0000_0002};
    t[1] = {4'h1, 4'h0, 4'h5, 8'h02, 32'h0000_0028};
    t[2] = {4'h2, 4'h0, 4'h6, 8'h00, 32'h0000_4624};
    t[3] = {4'h3, 4'h0, 4'h3, 8'h0c, 32'h0000_6000};
    t[4] = {4'h4, 4'h0, 4'h0, 8'h00, 32'h0000_0800};
    t[5] = {4'h4, 4'h1, 4'h2, 8'h00, 32'h0000_0000};
    t[6] = {4'h4, 4'h1, 4'h4, 8'h00, 32'h0000_0800};
    t[7] = {4'h5, 4'h0, 4'h5, 8'h04, 32'h0000_0140};
    t[8] = {4'h6, 4'h0, 4'h7, 8'h10, 32'h0003_8000};
    t[9] = {4'h7, 4'h0, 4'h2, 8'h04, 32'h0000_0080};
    t[10] = {4'h0, 4'h0, 4'h5, 8'h01, 32'h0000_0005};
    t[11] = {4'h1, 4'h0, 4'h2, 8'h02, 32'h0000_0010};
    t[12] = {4'h3, 4'h0, 4'h4, 8'h0c, 32'h0000_1000};
    @(posedge rstn);
    repeat (6) @(posedge clk);
    bus(8'h68, 32'h0000_0000, 4'hf, 1'h0);
    chk(rd, 32'h0000_0000);
    bus(8'h68, 32'hffff_ffff, 4'h1, 1'h1);
    bus(8'h68, 32'h0000_0000, 4'hf, 1'h0);
    chk(rd, 32'h0000_00ff);
    bus(8'h68, 32'hffff_ffff, 4'hf, 1'h1);
    bus(8'h68, 32'h0000_0000, 4'hf, 1'h0);
    chk(rd, 32'h0003_ffff);
    bus(8'h00, 32'hffff_ffff, 4'hf, 1'h1);
    bus(8'h00, 32'h0000_0000, 4'hf, 1'h0);
    chk(rd, 32'h0000_0000);
    bus(8'h78, 32'h0000_0007, 4'hf, 1'h1);
    for (k = 0; k < 13; k = k + 1)
    begin
      bus(8'h68, t[k][31:0] | 32'h1f00_0000, 4'hf, 1'h1);
      bus(8'h70, {28'h000_0000, t[k][47:44]}, 4'hf, 1'h1);
      fire(t[k][51:48]);
      repeat (12) @(posedge clk);
      chk({27'h0, fat, nf, fl, lf, irq}, {27'h0, t[k][42:40], t[k][40], |t[k][42:40]});
      bus(8'h68, 32'h0000_0000, 4'hf, 1'h0);
      chk({24'h0, rd[31:24]}, {24'h0, t[k][39:32]});
      if (k == 2)
      begin
        bus(8'h78, 32'h0000_0000, 4'hf, 1'h1);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        bus(8'h78, 32'h0000_0007, 4'hf, 1'h1);
      end
      bus(8'h68, 32'h1f00_0000, 4'hf, 1'h1);
      bus(8'h70, 32'h0000_0106, 4'hf, 1'h1);
      bus(8'h74, 32'h0000_0007, 4'hf, 1'h1);
      repeat (3) @(posedge clk);
      chk({28'h0, fat, nf, fl, irq}, 32'h0000_0000);
    end
    wrap_up;
  end
endmodule // link_error_escalation_test
bind lee_link_err lee_link_err_properties u_props (
  .i_clk_sys,
  .i_resetn,
  .i_wb_cyc,
  .i_wb_stb,
  .i_wb_we,
  .o_wb_ack,
  .i_req_valid,
  .i_req_posted,
  .i_req_nxa,
  .i_req_srcid,
  .i_link_init_complete,
  .o_nxa_resp_valid,
  .o_nxa_resp_srcid,
  .o_fatal_int,
  .o_link_failure,
  .o_irq
);
